/* cac_pkg.sv */
// Shared constants and carriers for the calendar alarm compare block.
package cac_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_MASK = 6'h02;
    localparam logic [5:0] IDX_SEC_ALARM = 6'h10;
    localparam logic [5:0] IDX_MIN_ALARM = 6'h11;
    localparam logic [5:0] IDX_HOUR_ALARM = 6'h12;
    localparam logic [5:0] IDX_DAY_ALARM = 6'h13;
    localparam logic [5:0] IDX_WDAY_ALARM = 6'h14;
    localparam logic [5:0] IDX_MON_ALARM = 6'h15;
    localparam logic [5:0] IDX_YEAR_ALARM = 6'h16;

    // Number of alarm fields and their byte width.
    localparam int FIELDS = 7;
    localparam int FW = 8;

    // Field layout: enable in every alarm byte, 12/24 mode in the current hours byte, PM or tens-20 in hours.
    localparam int EN_BIT = 7;
    localparam int HOUR_MODE_BIT = 6;
    localparam int PM_OR_TENS20_BIT = 5;

    // Value bits compared per field, seconds in the lowest byte.
    localparam logic [7:0] MASK_SEC = 8'h7f;
    localparam logic [7:0] MASK_MIN = 8'h7f;
    localparam logic [7:0] MASK_HOUR_12 = 8'h3f;
    localparam logic [7:0] MASK_HOUR_24 = 8'h3f;
    localparam logic [7:0] MASK_DAY = 8'h3f;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_MON = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'h7f;

    // Control, status and mask bit positions.
    localparam int ALARM_IRQ_ENABLE_BIT = 0;
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_SEEN_BIT = 1;
    localparam int ST_LIVE_BIT = 8;
    localparam int ST_MODE_BIT = 9;
    localparam int EVW = 2;

    // Reset values of every stored register.
    localparam logic [7:0] ALARM_RST = 8'h00;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [EVW-1:0] EV_RST = 2'h0;

    // Current time from the timekeeping counters; seconds sit lowest.
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] wday;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } cac_time_s;

endpackage

/* cac_alarm_regs.sv */
`timescale 1ns/10ps
// Small register file holding the alarm target bytes.
module cac_alarm_regs #(
    parameter int DEPTH = 7,
    parameter int WIDTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic [DEPTH*WIDTH-1:0] bank_o
);

    // The address width must reach every entry.
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("cac_alarm_regs: DEPTH exceeds address range");
    end

    // Every entry is visible at once, because the comparators need all of them.
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                bank_o[i*WIDTH +: WIDTH] <= WIDTH'(cac_pkg::ALARM_RST);
            end else if (we_i && (waddr_i == AW'(i))) begin
                bank_o[i*WIDTH +: WIDTH] <= wdata_i;
            end
        end
    end

    // Read data leave a register; an index past the end reads as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (int'(raddr_i) < DEPTH) begin
            rdata_o <= bank_o[int'(raddr_i)*WIDTH +: WIDTH];
        end else begin
            rdata_o <= '0;
        end
    end

endmodule

/* cac_field_cmp.sv */
`timescale 1ns/10ps
// Compares one alarm byte against one current time byte.
module cac_field_cmp #(
    parameter int WIDTH = 8,
    parameter int EN_POS = 7
) (
    input wire logic [WIDTH-1:0] target_i,
    input wire logic [WIDTH-1:0] current_i,
    input wire logic [WIDTH-1:0] mask_i,
    output logic enabled_o,
    output logic hit_o
);

    // The enable bit must lie inside the byte.
    if (EN_POS >= WIDTH) begin : g_chk
        $error("cac_field_cmp: EN_POS outside the byte");
    end

    // The enable bit itself is never part of the compared value.
    assign enabled_o = target_i[EN_POS];
    // A disabled field always agrees, so it cannot veto the match.
    assign hit_o = !enabled_o || (((target_i ^ current_i) & mask_i) == '0);

endmodule

/* cac_alarm_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Compare a field only while its enable is set.
// - First full match with irq enable sets flag, pin.
// - Disabled fields never affect the match result.
// - Seconds alarm: enable bit 7, BCD 0-59.
// - Minutes alarm: enable bit 7, BCD 0-59.
// - Hours alarm: bit 5 PM or tens, BCD.
// - Days alarm: enable bit 7, BCD 1-31.
// - Weekday alarm: enable bit 7, value 1-7.
// - Months alarm: enable bit 7, BCD 1-12.
// - Years alarm: enable bit 7, BCD 0-79.
// - Current hours bit 6 picks 12/24 mode.
module cac_alarm_top #(
    parameter int FIELDS = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire cac_pkg::cac_time_s cur_time_i,
    output logic alarm_int_n_o,
    output logic irq_o
);

    // The compare structure is built for exactly seven calendar fields.
    if (FIELDS != cac_pkg::FIELDS) begin : g_chk
        $error("cac_alarm_top: FIELDS must be seven");
    end

    localparam int FW = cac_pkg::FW;
    localparam int AW = 3;

    // Bus handshake state.
    logic ack_q;
    // Register index carried by the word address.
    logic [5:0] idx;
    // A request seen for the first time.
    logic req_new;
    // The write that takes effect at the acknowledged edge.
    logic wr_commit;
    // The index falls in the alarm page.
    logic is_alarm;
    // Offset of the index inside the alarm page.
    logic [AW-1:0] alarm_off;

    // Software control and event bookkeeping.
    logic alarm_irq_enable_q;
    logic [cac_pkg::EVW-1:0] sts_q;
    logic [cac_pkg::EVW-1:0] sts_d;
    logic [cac_pkg::EVW-1:0] msk_q;
    logic [cac_pkg::EVW-1:0] ev_set;
    logic [cac_pkg::EVW-1:0] ev_clr;

    // Read path.
    logic [FW-1:0] alarm_rd;
    logic [31:0] own_rd_q;
    logic alarm_sel_q;

    // Compare path.
    logic [FIELDS*FW-1:0] bank;
    logic [FIELDS*FW-1:0] cur_flat;
    logic [FIELDS*FW-1:0] masks;
    logic [FIELDS-1:0] en;
    logic [FIELDS-1:0] hit;
    logic twelve_hour;
    logic any_en;
    logic match_all;
    logic match_q;
    logic match_rise;
    logic int_n_q;
    logic irq_q;

    // Address decode works on word indices; byte lanes above lane 0 are ignored on writes.
    assign idx = wb_adr_i[7:2];
    assign req_new = wb_cyc_i && wb_stb_i && !ack_q;
    // A write lands on the edge where the master sees ack, and only then.
    assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign is_alarm = (idx >= cac_pkg::IDX_SEC_ALARM) && (idx <= cac_pkg::IDX_YEAR_ALARM);
    assign alarm_off = AW'(idx - cac_pkg::IDX_SEC_ALARM);

    // Ack rises one cycle after the request and falls in the next cycle,
    // so every access, mapped or not, takes exactly two cycles.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_new;
        end
    end

    assign wb_ack_o = ack_q;

    // The alarm targets live in their own register file.
    cac_alarm_regs #(
        .DEPTH(FIELDS),
        .WIDTH(FW),
        .AW(AW)
    ) u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_commit && is_alarm),
        .waddr_i(alarm_off),
        .wdata_i(wb_dat_i[FW-1:0]),
        .raddr_i(alarm_off),
        .rdata_o(alarm_rd),
        .bank_o(bank)
    );

    // Control register: alarm_irq_enable gates both the flag and the pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_irq_enable_q <= cac_pkg::CTRL_RST;
        end else if (wr_commit && (idx == cac_pkg::IDX_CTRL)) begin
            alarm_irq_enable_q <= wb_dat_i[cac_pkg::ALARM_IRQ_ENABLE_BIT];
        end
    end

    // Interrupt mask register, same layout as the status register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msk_q <= cac_pkg::EV_RST;
        end else if (wr_commit && (idx == cac_pkg::IDX_MASK)) begin
            msk_q <= wb_dat_i[cac_pkg::EVW-1:0];
        end
    end

    // Own registers are sampled when the request first appears; unmapped
    // indices read zero and writes to them are dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_rd_q <= '0;
            alarm_sel_q <= 1'b0;
        end else if (req_new) begin
            own_rd_q <= '0;
            alarm_sel_q <= is_alarm;
            case (idx)
                cac_pkg::IDX_CTRL: begin
                    own_rd_q[cac_pkg::ALARM_IRQ_ENABLE_BIT] <= alarm_irq_enable_q;
                end
                cac_pkg::IDX_STATUS: begin
                    own_rd_q[cac_pkg::EVW-1:0] <= sts_q;
                    own_rd_q[cac_pkg::ST_LIVE_BIT] <= match_all;
                    own_rd_q[cac_pkg::ST_MODE_BIT] <= twelve_hour;
                end
                cac_pkg::IDX_MASK: begin
                    own_rd_q[cac_pkg::EVW-1:0] <= msk_q;
                end
                default: begin
                    own_rd_q <= '0;
                end
            endcase
        end
    end

    // Data are only shown while ack is high, and zero otherwise.
    always_comb begin
        wb_dat_o = '0;
        if (ack_q && alarm_sel_q) begin
            wb_dat_o[FW-1:0] = alarm_rd;
        end else if (ack_q) begin
            wb_dat_o = own_rd_q;
        end
    end

    // The live time is flattened so that field i sits in byte i.
    assign cur_flat = cur_time_i;
    // Mode follows the running hours register, not the alarm byte.
    assign twelve_hour = cur_time_i.hour[cac_pkg::HOUR_MODE_BIT];

    // Per field compare masks; the enable bit is never compared.
    // In 12-hour mode bit 5 is the PM marker, in 24-hour mode the tens-20.
    always_comb begin
        masks = {cac_pkg::MASK_YEAR, cac_pkg::MASK_MON, cac_pkg::MASK_WDAY,
                 cac_pkg::MASK_DAY, cac_pkg::MASK_HOUR_24, cac_pkg::MASK_MIN,
                 cac_pkg::MASK_SEC};
        if (twelve_hour) begin
            masks[2*FW +: FW] = cac_pkg::MASK_HOUR_12;
        end
    end

    // One comparator per calendar field.
    for (genvar i = 0; i < FIELDS; i++) begin : g_cmp
        cac_field_cmp #(
            .WIDTH(FW),
            .EN_POS(cac_pkg::EN_BIT)
        ) u_cmp (
            .target_i(bank[i*FW +: FW]),
            .current_i(cur_flat[i*FW +: FW]),
            .mask_i(masks[i*FW +: FW]),
            .enabled_o(en[i]),
            .hit_o(hit[i])
        );
    end

    // All enabled fields must agree. With no field enabled there is no
    // alarm at all, otherwise a blank setup would fire immediately.
    assign any_en = |en;
    assign match_all = any_en && (&hit);

    // Only the first cycle of a match counts, so a match that lasts a
    // whole second raises a single event.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_all;
        end
    end

    assign match_rise = match_all && !match_q;

    // Event sources: the flag needs the irq enable, the seen bit does not.
    always_comb begin
        ev_set = '0;
        ev_set[cac_pkg::ST_FLAG_BIT] = match_rise && alarm_irq_enable_q;
        ev_set[cac_pkg::ST_SEEN_BIT] = match_rise;
        ev_clr = '0;
        if (wr_commit && (idx == cac_pkg::IDX_STATUS)) begin
            ev_clr = wb_dat_i[cac_pkg::EVW-1:0];
        end
        // A new event in the clearing cycle survives the clear.
        sts_d = (sts_q & ~ev_clr) | ev_set;
    end

    // Sticky status bits, cleared only by reset or by writing a one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_q <= cac_pkg::EV_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    // Pin low while the flag is set and interrupts are enabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_n_q <= 1'b1;
        end else begin
            int_n_q <= !(sts_q[cac_pkg::ST_FLAG_BIT] && alarm_irq_enable_q);
        end
    end

    // Level interrupt to the system, gated by the mask register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & msk_q);
        end
    end

    assign alarm_int_n_o = int_n_q;
    assign irq_o = irq_q;

    // Checks run in the one clock domain and pause during reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // The first cycle of a match with irq enable raises the flag.
    property p_flag_set;
        match_rise && alarm_irq_enable_q |=> sts_q[cac_pkg::ST_FLAG_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    // A raised flag with irq enable pulls the pin low one cycle later.
    property p_pin_low;
        sts_q[cac_pkg::ST_FLAG_BIT] && alarm_irq_enable_q |=> !alarm_int_n_o;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin not low");

    // Without any enabled field there is never a match.
    property p_no_enable;
        !any_en |-> !match_all;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("match without enable");

    // An enabled seconds field must equal the live seconds on a match.
    property p_sec_eq;
        match_all && bank[cac_pkg::EN_BIT] |-> bank[6:0] == cur_time_i.sec[6:0];
    endproperty
    a_sec_eq: assert property (p_sec_eq) else $error("seconds mismatch");

    // An enabled minutes field must equal the live minutes on a match.
    property p_min_eq;
        match_all && bank[FW+7] |-> bank[FW +: 7] == cur_time_i.min[6:0];
    endproperty
    a_min_eq: assert property (p_min_eq) else $error("minutes mismatch");

    // Hours compare six bits in both modes.
    property p_hour_eq;
        match_all && bank[2*FW+7] |-> bank[2*FW +: 6] == cur_time_i.hour[5:0];
    endproperty
    a_hour_eq: assert property (p_hour_eq) else $error("hours mismatch");

    // Weekday compares three bits only.
    property p_wday_eq;
        match_all && bank[4*FW+7] |-> bank[4*FW +: 3] == cur_time_i.wday[2:0];
    endproperty
    a_wday_eq: assert property (p_wday_eq) else $error("weekday mismatch");

    // Months compare five bits, years seven.
    property p_mon_year_eq;
        match_all |-> (!bank[5*FW+7] || bank[5*FW +: 5] == cur_time_i.mon[4:0]) &&
            (!bank[6*FW+7] || bank[6*FW +: 7] == cur_time_i.year[6:0]);
    endproperty
    a_mon_year_eq: assert property (p_mon_year_eq) else $error("date mismatch");

    // The flag holds until a status write with bit 0 set.
    property p_sticky;
        sts_q[cac_pkg::ST_FLAG_BIT] && !ev_clr[cac_pkg::ST_FLAG_BIT] |=>
            sts_q[cac_pkg::ST_FLAG_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    // Ack is a single-cycle pulse.
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

    // An enabled days field must equal the live day on a match.
    property p_day_eq;
        match_all && bank[3*FW+7] |-> bank[3*FW +: 6] == cur_time_i.day[5:0];
    endproperty
    a_day_eq: assert property (p_day_eq) else $error("days mismatch");

    // The system interrupt rises one cycle after an unmasked status bit.
    property p_irq_level;
        (|(sts_q & msk_q)) |=> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised");

    // Main scenarios worth seeing in simulation.
    c_match: cover property (match_rise && alarm_irq_enable_q);
    c_seen_only: cover property (match_rise && !alarm_irq_enable_q);
    c_hour12: cover property (match_rise && twelve_hour);
    c_irq: cover property (!irq_o ##1 irq_o);
    c_clear: cover property (sts_q[cac_pkg::ST_FLAG_BIT] ##1 !sts_q[cac_pkg::ST_FLAG_BIT]);

endmodule

/* cac_time_src.sv */
`timescale 1ns/10ps
// Model of the timekeeping counters that feed the live time bytes.
// Only the seconds byte advances, which is enough to make a fresh match.
module cac_time_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire cac_pkg::cac_time_s load_val_i,
    input wire logic tick_i,
    output cac_pkg::cac_time_s cur_time_o
);
    cac_pkg::cac_time_s time_q; // Current time and date bytes.

    // A load wins over a tick; seconds count in BCD from 00 to 59.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            time_q <= '0;
        end else if (load_i) begin
            time_q <= load_val_i;
        end else if (tick_i) begin
            if (time_q.sec[3:0] == 4'h9) begin
                time_q.sec[3:0] <= 4'h0;
                time_q.sec[6:4] <= (time_q.sec[6:4] == 3'h5) ? 3'h0 : time_q.sec[6:4] + 3'h1;
            end else begin
                time_q.sec[3:0] <= time_q.sec[3:0] + 4'h1;
            end
        end
    end

    // The hours byte bit 6 carries the 12/24 hour mode to the block.
    assign cur_time_o = time_q;
endmodule

/* cac_alarm_top_tb.sv */
`timescale 1ns/10ps
// Self-checking bench: Wishbone register calls plus a model of the time source.
module cac_alarm_top_tb;
    logic clk = 1'b0; // 250 MHz clock.
    logic rst = 1'b1; // Synchronous reset, held for five cycles.
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic int_n;
    logic irq;
    logic load = 1'b0;
    logic tick = 1'b0;
    cac_pkg::cac_time_s load_val = '0;
    cac_pkg::cac_time_s cur_t;
    int failures = 0;
    int samples_checked = 0;
    int i;
    logic [7:0] b;
    logic [31:0] q;
    // Boundary values of every field, and bits outside the compared range of hours, days, weekday and months.
    logic [55:0] tv = 56'h79_12_07_31_23_59_59;
    logic [55:0] spare = 56'h00_60_78_40_40_00_00;
    logic [7:0] st_a = {cac_pkg::IDX_STATUS, 2'b00};
    logic [7:0] ct_a = {cac_pkg::IDX_CTRL, 2'b00};
    logic [7:0] mk_a = {cac_pkg::IDX_MASK, 2'b00};

    // Free-running clock, 4 ns period.
    always #2 clk = ~clk;

    cac_alarm_top dut_u (
        .clk_i(clk),
        .rst_i(rst),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .cur_time_i(cur_t),
        .alarm_int_n_o(int_n),
        .irq_o(irq)
    );

    cac_time_src time_u (
        .clk_i(clk),
        .rst_i(rst),
        .load_i(load),
        .load_val_i(load_val),
        .tick_i(tick),
        .cur_time_o(cur_t)
    );

    // Byte address of alarm field i.
    function automatic logic [7:0] aadr(input int i);
        return {cac_pkg::IDX_SEC_ALARM + i[5:0], 2'b00};
    endfunction

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t word got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic g, input logic e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t pin got %b exp %b", $time, g, e);
        end
    endtask

    // One classic cycle; ack and read data are taken at the rising edge that shows ack high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b1) begin
            failures++;
            $display("BAD %0t no ack", $time);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, 4'h1, d, r);
    endtask

    // Reads a register and compares the bits selected by m.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 4'h1, 32'h0, r);
        chk_word(r & m, e);
    endtask

    // Waits n edges, then checks both interrupt outputs mid-cycle.
    task automatic pins(input int n, input logic en, input logic ei);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk_pin(int_n, en);
        chk_pin(irq, ei);
    endtask

    task automatic set_time(input logic [55:0] t);
        @(posedge clk);
        load <= 1'b1;
        load_val <= t;
        @(posedge clk);
        load <= 1'b0;
    endtask

    task automatic tick_once();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        pins(0, 1'b1, 1'b0);
        for (i = 0; i < 7; i++) begin
            rd_chk(aadr(i), 32'hff, 32'h0);
        end
        rd_chk(ct_a, 32'hff, 32'h0);
        rd_chk(st_a, 32'h3ff, 32'h0);
        $display("test reset done");
        // Every alarm byte stores all eight bits; unmapped and sel-less writes are dropped.
        for (i = 0; i < 7; i++) begin
            wr(aadr(i), 32'ha5 ^ i);
            rd_chk(aadr(i), 32'hff, 32'ha5 ^ i);
        end
        wb(1'b1, aadr(0), 4'h0, 32'h11, q);
        rd_chk(aadr(0), 32'hff, 32'ha5);
        wr(8'h7c, 32'hff);
        rd_chk(8'h7c, 32'hffffffff, 32'h0);
        for (i = 0; i < 7; i++) begin
            wr(aadr(i), 32'h0);
        end
        $display("test registers done");
        // Each field alone: matches on its value, misses one off, ignored when disabled.
        set_time(tv);
        rd_chk(st_a, 32'h100, 32'h0);
        for (i = 0; i < 7; i++) begin
            b = tv[8*i +: 8];
            wr(aadr(i), {24'h0, 8'h80 | b | spare[8*i +: 8]});
            rd_chk(st_a, 32'h100, 32'h100);
            wr(aadr(i), {24'h0, 8'h80 | (b ^ 8'h01)});
            rd_chk(st_a, 32'h100, 32'h0);
            wr(aadr(i), {24'h0, b ^ 8'h01});
        end
        $display("test fields done");
        // Twelve hour mode: PM 11 matches, AM 11 does not.
        set_time(56'h79_12_07_31_71_59_59);
        wr(aadr(2), 32'hb1);
        rd_chk(st_a, 32'h300, 32'h300);
        wr(aadr(2), 32'h91);
        rd_chk(st_a, 32'h300, 32'h200);
        wr(aadr(2), 32'h0);
        $display("test hours done");
        // Alarm event through the seconds counter, then sticky flag and clearing.
        wr(st_a, 32'h3);
        wr(ct_a, 32'h1);
        wr(mk_a, 32'h1);
        set_time(56'h79_12_07_31_23_59_10);
        wr(aadr(0), 32'h92);
        pins(2, 1'b1, 1'b0);
        rd_chk(st_a, 32'h3, 32'h0);
        tick_once();
        tick_once();
        pins(3, 1'b0, 1'b1);
        rd_chk(st_a, 32'h3, 32'h3);
        tick_once();
        pins(3, 1'b0, 1'b1);
        rd_chk(st_a, 32'h101, 32'h1);
        wr(st_a, 32'h1);
        pins(3, 1'b1, 1'b0);
        rd_chk(st_a, 32'h3, 32'h2);
        // Masked event: pin still falls, system interrupt stays low.
        wr(st_a, 32'h3);
        wr(mk_a, 32'h0);
        wr(aadr(0), 32'h93);
        pins(3, 1'b0, 1'b0);
        rd_chk(st_a, 32'h3, 32'h3);
        // With the irq enable off only the seen bit records the match.
        wr(aadr(0), 32'h0);
        wr(st_a, 32'h3);
        wr(ct_a, 32'h0);
        wr(aadr(0), 32'h93);
        rd_chk(st_a, 32'h3, 32'h2);
        pins(1, 1'b1, 1'b0);
        $display("test interrupt done");
        // A reset in mid-run clears the sticky bits and the stored seconds target.
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(st_a, 32'h3, 32'h0);
        rd_chk(aadr(0), 32'hff, 32'h0);
        pins(1, 1'b1, 1'b0);
        $display("test second reset done");
        test_done();
    end

    // Watchdog: the tests need well under 2000 cycles.
    initial begin
        #(4 * 5000);
        failures++;
        $display("BAD %0t timeout", $time);
        test_done();
    end
endmodule
